/* ars_pkg.sv */
/*
 * Package for the read-sectors command block: register map, field
 * positions, reset values, counts, the media carriers and the states.
 * Assumes a 32-bit register bus with byte addresses and a single 100 MHz clock.
 */
package ars_pkg;

	// Register map, one aligned 32-bit word each, data in the low bits
	localparam logic [7:0] ARS_OFS_DATA    = 8'h00;
	localparam logic [7:0] ARS_OFS_FEATURE = 8'h04;
	localparam logic [7:0] ARS_OFS_SECCNT  = 8'h08;
	localparam logic [7:0] ARS_OFS_SECNUM  = 8'h0c;
	localparam logic [7:0] ARS_OFS_CYLLO   = 8'h10;
	localparam logic [7:0] ARS_OFS_CYLHI   = 8'h14;
	localparam logic [7:0] ARS_OFS_DRVHEAD = 8'h18;
	localparam logic [7:0] ARS_OFS_CMDSTAT = 8'h1c;
	localparam logic [7:0] ARS_OFS_ERROR   = 8'h20;
	localparam logic [7:0] ARS_OFS_IRQSTAT = 8'h24;
	localparam logic [7:0] ARS_OFS_IRQMASK = 8'h28;

	// Command codes accepted as read sectors
	localparam logic [7:0] ARS_CMD_READ_RETRY   = 8'h20;
	localparam logic [7:0] ARS_CMD_READ_NORETRY = 8'h21;

	// Field positions
	localparam int ARS_DH_LBA   = 6;
	localparam int ARS_DH_DRV   = 4;
	localparam int ARS_ERR_UNC  = 6;
	localparam int ARS_ERR_IDNF = 4;
	localparam int ARS_IRQ_DRQ  = 0;
	localparam int ARS_IRQ_DONE = 1;
	localparam int ARS_IRQ_ERR  = 2;
	localparam logic [7:0] ARS_ERR_ZERO_MASK = 8'haf;

	// Reset values
	localparam logic [7:0] ARS_RST_TF   = 8'h00;
	localparam logic [2:0] ARS_RST_IRQ  = 3'h0;
	localparam logic       ARS_RST_WAIT = 1'b1;

	// Counts: 512-byte sectors moved as 16-bit words
	localparam int         ARS_SECTOR_BYTES = 512;
	localparam logic [8:0] ARS_SECTOR_WORDS = 9'(ARS_SECTOR_BYTES / 2);
	localparam logic [8:0] ARS_COUNT_ZERO   = 9'h100;

	// Geometry used to step a CHS address (plain defaults)
	localparam logic [7:0] ARS_CHS_SPT       = 8'h3f;
	localparam logic [3:0] ARS_CHS_LAST_HEAD = 4'hf;

	typedef struct packed {
		logic        lba;
		logic        drive;
		logic [27:0] addr;
	} ars_med_req_t;

	typedef struct packed {
		logic unc;
		logic idnf;
		logic corr;
	} ars_med_sts_t;

	typedef enum logic [1:0] {ARS_IDLE, ARS_FETCH, ARS_XFER} ars_state_t;

endpackage : ars_pkg

/* ars_addr_step.sv */
/*
 * Next-sector address for the read-sectors block, LBA or CHS form.
 * Assumes CHS addresses are {head, cylinder, sector} with 1-based sectors.
 */
`timescale 1ns/1ns
module ars_addr_step
	import ars_pkg::*;
(
	input  wire logic        lba,
	input  wire logic [27:0] addr,
	output logic      [27:0] nxt
);
	wire [3:0]  head   = addr[27:24];
	wire [15:0] cyl    = addr[23:8];
	wire [7:0]  sect   = addr[7:0];
	wire        sect_w = (sect >= ARS_CHS_SPT);
	wire        head_w = (head == ARS_CHS_LAST_HEAD);

	// CHS wraps sector into head into cylinder; LBA is a plain count
	assign nxt = lba    ? 28'(addr + 28'h1) :
	             !sect_w ? {head, cyl, 8'(sect + 8'h1)} :
	             !head_w ? {4'(head + 4'h1), cyl, 8'h01} :
	                       {4'h0, 16'(cyl + 16'h1), 8'h01};
endmodule : ars_addr_step

/* ars_read_sectors.sv */
/*
 * Read-sectors command interpreter: task file registers on an Avalon-MM
 * slave, command decode, sector sequencing toward a media engine, and
 * completion status. Assumes the media engine sits on the same clock and
 * answers each sector request with one status pulse, then 256 data words.
 */
// Overview of operation
// - Command codes 20h and 21h both start a read-sectors operation.
// - Reading begins at the address held in the task file at command time.
// - Consecutive sectors are sent until the requested count is delivered.
// - Drive/head bit 6 selects LBA, bit 4 drive; fields form the address.
// - At the end the task file holds the last good sector address, or the start address if the first sector fails.
// - On an unrecoverable error sector count holds sectors not transferred.
// - Only UNC and IDNF may be set in the error register.
`timescale 1ns/1ns
module ars_read_sectors
	import ars_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [7:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [3:0]   avs_byteenable,
	input  wire logic [31:0]  avs_writedata,
	output logic      [31:0]  avs_readdata,
	output logic              avs_waitrequest,
	output logic              med_req_valid,
	output ars_med_req_t      med_req,
	input  wire logic         med_ack,
	input  wire ars_med_sts_t med_sts,
	input  wire logic         med_valid,
	input  wire logic [15:0]  med_data,
	output logic              med_ready,
	output logic              irq
);
	// Reset release through two flops; assertion stays asynchronous
	logic [1:0] rst_ff_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) rst_ff_q <= 2'b00;
		else        rst_ff_q <= {rst_ff_q[0], 1'b1};
	end
	wire rst_sync_n = rst_ff_q[1];

	ars_state_t  st_q;
	logic [7:0]  feat_q, sc_q, sn_q, cl_q, ch_q, dh_q;
	logic [27:0] cur_q, good_q;
	logic [8:0]  remain_q, words_q;
	logic        lba_q, drv_q, unc_q, idnf_q, corr_q, err_q;
	logic        wait_q, req_v_q, ready_q, irq_q;
	logic [31:0] rdata_q;
	logic [2:0]  irq_st_q, irq_mask_q;
	logic [27:0] nxt_addr;

	// Bus decode: a request is answered once, then completes on the low wait
	wire       bus_req   = avs_read | avs_write;
	wire       xfer      = (st_q == ARS_XFER);
	wire       busy      = (st_q != ARS_IDLE);
	wire       data_rd   = avs_read && (avs_address == ARS_OFS_DATA);
	wire       go        = bus_req && wait_q && (!(data_rd && xfer) || med_valid);
	wire       commit_wr = avs_write && !wait_q && avs_byteenable[0];
	wire [7:0] wd        = avs_writedata[7:0];
	wire       tf_wr     = commit_wr && !busy;

	// Both retry flavours decode to the same command
	wire cmd_code = (wd == ARS_CMD_READ_RETRY) || (wd == ARS_CMD_READ_NORETRY);
	wire cmd_go   = tf_wr && (avs_address == ARS_OFS_CMDSTAT) && cmd_code;

	// Start address from the task file fields
	wire [27:0] tf_addr = {dh_q[3:0], ch_q, cl_q, sn_q};

	// Sector sequencing events
	wire sts_ack  = (st_q == ARS_FETCH) && med_ack;
	wire sts_bad  = sts_ack && (med_sts.unc || med_sts.idnf);
	wire pop      = go && data_rd && xfer;
	wire sec_done = pop && (words_q == 9'(ARS_SECTOR_WORDS - 9'h1));
	wire last_sec = (remain_q == 9'h001);
	wire finish   = sec_done && last_sec;
	wire abort    = sts_bad;
	wire wb       = finish || abort;

	// End-of-command writeback values
	wire [27:0] wb_addr = finish ? cur_q : good_q;
	wire [7:0]  wb_sc   = finish ? 8'h00 : remain_q[7:0];

	// Status: DRDY and DSC held set, DWF and IDX never set
	wire [7:0] status_w = {busy, 1'b1, 1'b0, 1'b1, xfer, corr_q, 1'b0, err_q};
	wire [7:0] error_w  = {1'b0, unc_q, 1'b0, idnf_q, 4'h0};

	// Interrupt events and write-one-to-clear; a new event beats the clear
	wire [2:0] irq_ev  = {abort, finish, sts_ack && !sts_bad};
	wire       irq_wr  = commit_wr && (avs_address == ARS_OFS_IRQSTAT);
	wire [2:0] irq_clr = irq_wr ? wd[2:0] : 3'h0;
	wire [2:0] irq_d   = (irq_st_q & ~irq_clr) | irq_ev;

	// Read mux; the write-only command reads as status, unmapped words read as zero
	wire [7:0] rd8 =
		(avs_address == ARS_OFS_SECCNT)  ? sc_q :
		(avs_address == ARS_OFS_SECNUM)  ? sn_q :
		(avs_address == ARS_OFS_CYLLO)   ? cl_q :
		(avs_address == ARS_OFS_CYLHI)   ? ch_q :
		(avs_address == ARS_OFS_DRVHEAD) ? dh_q :
		(avs_address == ARS_OFS_CMDSTAT) ? status_w :
		(avs_address == ARS_OFS_ERROR)   ? error_w :
		(avs_address == ARS_OFS_IRQSTAT) ? {5'h00, irq_st_q} :
		(avs_address == ARS_OFS_IRQMASK) ? {5'h00, irq_mask_q} : 8'h00;
	wire [31:0] rd_mux = (data_rd && xfer) ? {16'h0000, med_data} : {24'h000000, rd8};

	ars_addr_step u_step (
		.lba  (lba_q),
		.addr (cur_q),
		.nxt  (nxt_addr)
	);

	// Bus answer: one cycle of low wait with read data beside it
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wait_q  <= ARS_RST_WAIT;
			rdata_q <= 32'h00000000;
			ready_q <= 1'b0;
		end else begin
			wait_q  <= !go;
			rdata_q <= go ? rd_mux : rdata_q;
			ready_q <= pop;
		end
	end

	// Host-written registers; feature_select is stored but steers nothing
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			feat_q     <= ARS_RST_TF;
			irq_mask_q <= ARS_RST_IRQ;
		end else begin
			if (tf_wr && avs_address == ARS_OFS_FEATURE) feat_q <= wd;
			if (commit_wr && avs_address == ARS_OFS_IRQMASK) irq_mask_q <= wd[2:0];
		end
	end

	// Task file: host writes while idle, device writes back at the end
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{sc_q, sn_q, cl_q, ch_q, dh_q} <= {5{ARS_RST_TF}};
		end else if (wb) begin
			dh_q <= {dh_q[7:4], wb_addr[27:24]};
			ch_q <= wb_addr[23:16];
			cl_q <= wb_addr[15:8];
			sn_q <= wb_addr[7:0];
			sc_q <= wb_sc;
		end else if (tf_wr) begin
			if (avs_address == ARS_OFS_SECCNT)  sc_q <= wd;
			if (avs_address == ARS_OFS_SECNUM)  sn_q <= wd;
			if (avs_address == ARS_OFS_CYLLO)   cl_q <= wd;
			if (avs_address == ARS_OFS_CYLHI)   ch_q <= wd;
			if (avs_address == ARS_OFS_DRVHEAD) dh_q <= wd;
		end
	end

	// Sequencer: fetch a sector, stream its words, repeat until count spent
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_q    <= ARS_IDLE;
			req_v_q <= 1'b0;
		end else begin
			req_v_q <= 1'b0;
			case (st_q)
				ARS_IDLE: begin
					if (cmd_go) begin
						st_q    <= ARS_FETCH;
						req_v_q <= 1'b1;
					end
				end
				ARS_FETCH: begin
					if (sts_ack) st_q <= sts_bad ? ARS_IDLE : ARS_XFER;
				end
				ARS_XFER: begin
					if (finish) begin
						st_q <= ARS_IDLE;
					end else if (sec_done) begin
						st_q    <= ARS_FETCH;
						req_v_q <= 1'b1;
					end
				end
				default: st_q <= ARS_IDLE;
			endcase
		end
	end

	// Address and count tracking
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{cur_q, good_q}  <= 56'h0;
			{lba_q, drv_q}   <= 2'b00;
			remain_q         <= 9'h000;
			words_q          <= 9'h000;
		end else if (cmd_go) begin
			cur_q    <= tf_addr;
			good_q   <= tf_addr;
			lba_q    <= dh_q[ARS_DH_LBA];
			drv_q    <= dh_q[ARS_DH_DRV];
			remain_q <= (sc_q == 8'h00) ? ARS_COUNT_ZERO : {1'b0, sc_q};
			words_q  <= 9'h000;
		end else if (sec_done) begin
			good_q   <= cur_q;
			cur_q    <= last_sec ? cur_q : nxt_addr;
			remain_q <= 9'(remain_q - 9'h1);
			words_q  <= 9'h000;
		end else if (pop) begin
			words_q  <= 9'(words_q + 9'h1);
		end
	end

	// Outcome flags, cleared when the next command starts
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{unc_q, idnf_q, corr_q, err_q} <= 4'h0;
		end else if (cmd_go) begin
			{unc_q, idnf_q, corr_q, err_q} <= 4'h0;
		end else if (sts_ack) begin
			unc_q  <= med_sts.unc;
			idnf_q <= med_sts.idnf;
			corr_q <= corr_q | med_sts.corr;
			err_q  <= sts_bad;
		end
	end

	// Sticky interrupt status and masked level output
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_st_q <= ARS_RST_IRQ;
			irq_q    <= 1'b0;
		end else begin
			irq_st_q <= irq_d;
			irq_q    <= |(irq_st_q & irq_mask_q);
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign med_req_valid   = req_v_q;
	assign med_req         = '{lba: lba_q, drive: drv_q, addr: cur_q};
	assign med_ready       = ready_q;
	assign irq             = irq_q;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);

	AST_CMD_START: assert property (cmd_go |=> st_q == ARS_FETCH && req_v_q)
		else $error("read command not started");
	AST_START_ADDR: assert property (cmd_go |=> med_req.addr == $past(tf_addr))
		else $error("first request address differs from task file");
	AST_LBA_SEL: assert property (cmd_go |=> med_req.lba == $past(dh_q[6])
		&& med_req.drive == $past(dh_q[4]))
		else $error("lba or drive select not taken from drive/head");
	AST_COUNT_END: assert property (sec_done && remain_q != 9'h001 |=> busy && remain_q
		== $past(remain_q) - 9'h1)
		else $error("sector count not stepped or read ended early");
	AST_END_STATUS: assert property ($fell(busy) |-> status_w[7:4] == 4'b0101
		&& !status_w[3] && !status_w[1])
		else $error("bad status after completion");
	AST_LAST_GOOD: assert property (finish |=> {dh_q[3:0], ch_q, cl_q, sn_q}
		== $past(cur_q) && sc_q == 8'h00)
		else $error("task file not loaded with last sector");
	AST_LEFT_COUNT: assert property (abort |=> sc_q == $past(remain_q[7:0]) && err_q)
		else $error("remaining count not reported on error");
	AST_ERR_BITS: assert property ((error_w & ARS_ERR_ZERO_MASK) == 8'h00)
		else $error("forbidden error bit set");
	AST_DRQ_WORDS: assert property (pop |-> status_w[3] ##1 med_ready)
		else $error("data word moved without drq");
	AST_ZERO_COUNT: assert property (cmd_go && sc_q == 8'h00 |=> remain_q == 9'h100)
		else $error("zero count not taken as 256");
	AST_IRQ_LEVEL: assert property (|(irq_st_q & irq_mask_q) |=> irq)
		else $error("interrupt not raised");

	COV_CMD:    cover property (cmd_go);
	COV_FINISH: cover property (finish);
	COV_ABORT:  cover property (abort);
	COV_MULTI:  cover property (sec_done && !last_sec);
endmodule : ars_read_sectors

/* ars_media_model.sv */
/*
 * Media engine model for the read-sectors bench: answers each fetch
 * with one status pulse, then 256 words held until consumed, or no words for a failing address.
 * Assumes the block's clock and the ars_pkg carriers.
 */
`timescale 1ns/1ns
module ars_media_model
	import ars_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         med_req_valid,
	input  wire ars_med_req_t med_req,
	input  wire logic         med_ready,
	input  wire logic         fail_en,
	input  wire logic [27:0]  fail_addr,
	input  wire ars_med_sts_t fail_sts,
	input  wire logic [3:0]   lat,
	output ars_med_sts_t      med_sts,
	output logic              med_ack,
	output logic              med_valid,
	output logic [15:0]       med_data
);
	int   reqs = 0;
	int   served = 0;
	logic bad;

	// Count fetches apart from the streamer so a pulse is never missed
	always @(posedge sys_clk) if (med_req_valid === 1'b1) reqs++;

	// Status pulse, then words in order; idle status shows inverted status, idle data inverted data only with nonzero lat
	initial begin
		med_ack = 1'b0;
		med_valid = 1'b0;
		med_sts = '0;
		med_data = 16'h0000;
		forever begin
			@(posedge sys_clk);
			if (reqs != served) begin
				served++;
				repeat (lat) @(posedge sys_clk);
				bad = fail_en && med_req.addr == fail_addr;
				med_ack <= 1'b1;
				med_sts <= bad ? fail_sts : '0;
				@(posedge sys_clk);
				med_ack <= 1'b0;
				med_sts <= ~med_sts;
				for (int i = 0; i < 256 && !bad; i++) begin
					med_valid <= 1'b1;
					med_data <= {med_req.lba, med_req.addr[6:0], 8'(i)};
					do @(posedge sys_clk); while (med_ready !== 1'b1);
					if (lat != 0) begin
						med_valid <= 1'b0;
						med_data <= ~med_data;
						repeat (lat) @(posedge sys_clk);
					end
				end
				med_valid <= 1'b0;
			end
		end
	end
endmodule : ars_media_model

/* ars_read_sectors_test.sv */
/*
 * Self-checking bench for the read-sectors block over Avalon-MM.
 * Assumes ars_media_model on the media side and a 100 MHz clock.
 */
`timescale 1ns/1ns
module ars_read_sectors_test
	import ars_pkg::*;
;
	logic         sys_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [7:0]   avs_address = 8'h00;
	logic         avs_read = 1'b0;
	logic         avs_write = 1'b0;
	logic [31:0]  avs_writedata = 32'h0;
	logic [31:0]  avs_readdata, q;
	logic         avs_waitrequest, med_req_valid, med_ack, med_valid, med_ready, irq;
	ars_med_req_t med_req;
	ars_med_sts_t med_sts;
	ars_med_sts_t fail_sts = '0;
	logic [15:0]  med_data;
	logic         fail_en = 1'b0;
	logic [27:0]  fail_addr = 28'h0;
	logic [3:0]   lat = 4'h0;
	int           mismatches = 0;
	int           checks = 0;

	always #5 sys_clk = ~sys_clk;

	ars_read_sectors dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .med_req_valid(med_req_valid), .med_req(med_req),
		.med_ack(med_ack), .med_sts(med_sts), .med_valid(med_valid), .med_data(med_data),
		.med_ready(med_ready), .irq(irq));

	ars_media_model media (.sys_clk(sys_clk), .med_req_valid(med_req_valid),
		.med_req(med_req), .med_ready(med_ready), .fail_en(fail_en), .fail_addr(fail_addr),
		.fail_sts(fail_sts), .lat(lat), .med_sts(med_sts), .med_ack(med_ack),
		.med_valid(med_valid), .med_data(med_data));

	task finish_test;
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// Hang guard: over ten times the cycles that the slow-media scenarios need
	initial begin
		#500000;
		mismatches++;
		finish_test;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Held request until waitrequest is sampled low, then release
	// Only the hang guard ends a wait that never comes
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask : wr

	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rc

	// Whole command: load task file, stream sectors, judge end state
	task automatic run(input logic [7:0] cmd, dh, hi, lo, sn, cnt, input int fk,
		input logic [7:0] err);
		logic [27:0] a, last;
		int k;
		a = {dh[3:0], hi, lo, sn};
		fail_en <= fk >= 0;
		fail_addr <= a + 28'(fk);
		fail_sts <= {err[6], err[4], 1'b0};
		wr(ARS_OFS_IRQSTAT, 8'h07);
		wr(ARS_OFS_FEATURE, 8'hff);
		wr(ARS_OFS_SECCNT, cnt);
		wr(ARS_OFS_SECNUM, sn);
		wr(ARS_OFS_CYLLO, lo);
		wr(ARS_OFS_CYLHI, hi);
		wr(ARS_OFS_DRVHEAD, dh);
		wr(ARS_OFS_CMDSTAT, cmd);
		for (int s = 0; s < cnt; s++) begin
			k = 0;
			do begin
				bus(1'b0, ARS_OFS_CMDSTAT, 32'h0);
				k++;
			end while (q[3] !== 1'b1 && q[7] !== 1'b0 && k < 500);
			if (q[3] !== 1'b1) break;
			for (int w = 0; w < 256; w++) begin
				bus(1'b0, ARS_OFS_DATA, 32'h0);
				chk(q, {16'h0, dh[6], 7'(a + 28'(s)), 8'(w)});
			end
		end
		last = fk > 0 ? a + 28'(fk - 1) : (fk == 0 ? a : a + 28'(cnt - 1));
		rc(ARS_OFS_CMDSTAT, 32'hff, {24'h0, 7'h28, 1'(fk >= 0)});
		rc(ARS_OFS_ERROR, 32'hff, {24'h0, err});
		rc(ARS_OFS_SECCNT, 32'hff, fk >= 0 ? 32'(cnt) - 32'(fk) : 32'h0);
		rc(ARS_OFS_SECNUM, 32'hff, {24'h0, last[7:0]});
		rc(ARS_OFS_CYLLO, 32'hff, {24'h0, last[15:8]});
		rc(ARS_OFS_CYLHI, 32'hff, {24'h0, last[23:16]});
		rc(ARS_OFS_DRVHEAD, 32'h0f, {28'h0, last[27:24]});
		fail_en <= 1'b0;
	endtask : run

	task t_reset;
		rc(ARS_OFS_CMDSTAT, 32'hff, 32'h50);
		for (int o = 8; o <= 40; o += 4) rc(8'(o), 32'hff, (o == 28) ? 32'h50 : 32'h0);
		rc(8'h30, 32'hffffffff, 32'h0);
		rc(ARS_OFS_DATA, 32'hffffffff, 32'h0);
		chk(irq, 1'b0);
	endtask : t_reset

	// LBA low byte wraps fe..00 across three sectors; done interrupt
	task t_lba;
		wr(ARS_OFS_IRQMASK, 8'h02);
		run(ARS_CMD_READ_RETRY, 8'h4a, 8'h23, 8'h45, 8'hfe, 8'd3, -1, 8'h00);
		chk(irq, 1'b1);
		rc(ARS_OFS_IRQSTAT, 32'h02, 32'h02);
		wr(ARS_OFS_IRQSTAT, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1'b0);
		wr(ARS_OFS_IRQMASK, 8'h00);
	endtask : t_lba

	// CHS with drive 1 and a slow media side
	task t_chs;
		lat <= 4'd5;
		run(ARS_CMD_READ_NORETRY, 8'h13, 8'h01, 8'h02, 8'h01, 8'd1, -1, 8'h00);
		chk(med_req.drive, 1'b1);
		chk(med_req.lba, 1'b0);
	endtask : t_chs

	// Errors mid-run and on the first sector, with interrupts masked
	task t_err;
		lat <= 4'd2;
		run(ARS_CMD_READ_RETRY, 8'h40, 8'h00, 8'h00, 8'h10, 8'd3, 1, 8'h40);
		run(ARS_CMD_READ_RETRY, 8'h40, 8'h00, 8'h00, 8'h10, 8'd2, 0, 8'h10);
		chk(irq, 1'b0);
	endtask : t_err

	task t_badcmd;
		wr(ARS_OFS_CMDSTAT, 8'h30);
		repeat (4) @(posedge sys_clk);
		rc(ARS_OFS_CMDSTAT, 32'hff, 32'h51);
	endtask : t_badcmd

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset;
		t_lba;
		t_chs;
		t_err;
		t_badcmd;
		finish_test;
	end
endmodule : ars_read_sectors_test
